// >>> include/ascd_pkg.sv
// constants and types of the converter sequence and data control register
package ascd_pkg;

	// ====================================================
	// register map
	localparam logic [15:0] CTRL_OFFSET   = 16'h1108;
	localparam logic [15:0] RESULT_OFFSET = 16'h1180;
	localparam logic [31:0] CTRL_RESET    = 32'h00000000;
	localparam logic [31:0] CTRL_WMASK    = 32'h1F1FFD07;

	// ====================================================
	// field positions
	localparam int LAST_LSB   = 24;
	localparam int FIRST_LSB  = 16;
	localparam int COUNT_LSB  = 11;
	localparam int QUEUE_BIT  = 10;
	localparam int TRIG_BIT   = 8;
	localparam int DEPTH_LSB  = 1;
	localparam int FORMAT_BIT = 0;

	// ====================================================
	// field limits and widths
	localparam int SLOT_W  = 5;
	localparam int COUNT_W = 5;
	localparam int RAW_W   = 12;
	localparam int READ_W  = 16;
	localparam logic [4:0] SLOT_MAX  = 5'h17;
	localparam logic [4:0] COUNT_MAX = 5'h18;
	localparam logic [4:0] COUNT_MIN = 5'h01;
	localparam logic [4:0] SLOT_ONE  = 5'h01;

	// ====================================================
	// encodings
	localparam logic [1:0] DEPTH_12 = 2'h0;
	localparam logic [1:0] DEPTH_10 = 2'h1;
	localparam logic [1:0] DEPTH_8  = 2'h2;
	localparam logic [1:0] DEPTH_12B = 2'h3;

	typedef enum logic [1:0] {
		ASCD_ONE_SLOT_ONCE,
		ASCD_SPAN_ONCE,
		ASCD_ONE_SLOT_REPEAT,
		ASCD_SPAN_REPEAT
	} ascd_seq_mode_e;

	typedef enum logic [1:0] {
		ASCD_BITS_12,
		ASCD_BITS_10,
		ASCD_BITS_8
	} ascd_depth_e;

endpackage

// >>> include/ascd_fmt_if.sv
// carrier between the control block and the read-back formatter
`timescale 1ns/10ps
interface ascd_fmt_if;
	logic [ascd_pkg::RAW_W-1:0]  raw_result;
	ascd_pkg::ascd_depth_e       depth;
	logic                        signed_fmt;
	logic [ascd_pkg::READ_W-1:0] readback;

	modport ctrl (
		output raw_result,
		output depth,
		output signed_fmt,
		input  readback
	);
	modport fmt (
		input  raw_result,
		input  depth,
		input  signed_fmt,
		output readback
	);
endinterface

// >>> src/ascd_readback_fmt.sv
// read-back formatter: unsigned right aligned or signed left aligned
`timescale 1ns/10ps
module ascd_readback_fmt (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// carrier
	ascd_fmt_if.fmt   fmt_io
);
	// ====================================================
	// format selection
	logic [ascd_pkg::READ_W-1:0] unsigned_word;
	logic [ascd_pkg::READ_W-1:0] signed_word;
	logic [ascd_pkg::READ_W-1:0] readback_next;
	logic [ascd_pkg::READ_W-1:0] readback_reg;
	logic [ascd_pkg::RAW_W-1:0]  raw;

	assign raw = fmt_io.raw_result;
	assign unsigned_word = {4'h0, raw};

	// offset binary to two's complement: invert the top bit, push to bit 15
	always_comb begin
		signed_word = 16'h0000;
		case (fmt_io.depth)
			ascd_pkg::ASCD_BITS_10: signed_word = {~raw[9], raw[8:0], 6'h00};
			ascd_pkg::ASCD_BITS_8:  signed_word = {~raw[7], raw[6:0], 8'h00};
			default:                signed_word = {~raw[11], raw[10:0], 4'h0};
		endcase
	end

	assign readback_next = fmt_io.signed_fmt ? signed_word : unsigned_word;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			readback_reg <= 16'h0000;
		end else begin
			readback_reg <= readback_next;
		end
	end

	assign fmt_io.readback = readback_reg;
endmodule

// >>> src/ascd_ctrl_top.sv
// converter sequence and data control register with apb slave
//
// Notes on behaviour
// - last slot of a sequence comes from bits 28-24, slots 0x00 to 0x17.
// - first or single slot comes from bits 20-16, slots 0x00 to 0x17.
// - samples moved per transfer trigger come from bits 15-11, up to 18h.
// - bit 10 set selects queue based result handling, clear selects direct.
// - transfer triggers are issued only while bit 8 is set.
// - transfer done clears bit 8; software sets it again for more triggers.
// - bits 2-1 select 12, 10 or 8 bit results for 0h, 1h, 2h.
// - depth value 3 behaves as 12 bits, like value 0.
// - results are always kept internally as unsigned binary.
// - bit 0 clear reads unsigned, set reads left aligned two's complement.
// - register sits at 1108h and resets to all zeros.
// - single modes use first slot only, span modes step first to last.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module ascd_ctrl_top (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [15:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// converter core
	input  wire logic [1:0]  i_sequence_mode_select,
	input  wire logic        i_seq_start,
	input  wire logic        i_sample_valid,
	input  wire logic [11:0] i_sample_data,
	output logic      [4:0]  o_conversion_slot,
	output logic             o_seq_busy,
	output logic             o_seq_done,
	output logic      [1:0]  o_bit_depth,
	output logic             o_queue_mode_enable,
	// transfer controller
	input  wire logic        i_transfer_done,
	output logic             o_transfer_trigger,
	output logic      [4:0]  o_samples_per_transfer,
	output logic      [15:0] o_readback_data
);
	// ====================================================
	// reset release
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// ====================================================
	// apb decode
	logic sel_ctrl;
	logic sel_result;
	logic mapped;
	logic setup_phase;
	logic access_phase;
	logic wr_ctrl;

	assign sel_ctrl     = (i_paddr == ascd_pkg::CTRL_OFFSET);
	assign sel_result   = (i_paddr == ascd_pkg::RESULT_OFFSET);
	assign mapped       = sel_ctrl || sel_result;
	assign setup_phase  = i_psel && !i_penable;
	assign access_phase = i_psel && i_penable;
	assign wr_ctrl      = access_phase && i_pwrite && sel_ctrl;

	// zero wait states: every access completes in its first access cycle
	assign o_pready  = access_phase;
	assign o_pslverr = access_phase && !mapped;

	// ====================================================
	// control register
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] ctrl_written;
	logic        trig_en_next;

	// writable fields only; reserved positions stay zero
	assign ctrl_written = i_pwdata & ascd_pkg::CTRL_WMASK;

	// a software write wins over a done in the same cycle, so a re-arm is kept
	always_comb begin
		trig_en_next = ctrl_reg[ascd_pkg::TRIG_BIT];
		if (wr_ctrl) begin
			trig_en_next = ctrl_written[ascd_pkg::TRIG_BIT];
		end else if (i_transfer_done) begin
			trig_en_next = 1'b0;
		end
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next = ctrl_written;
		end
		ctrl_next[ascd_pkg::TRIG_BIT] = trig_en_next;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl_reg <= ascd_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ====================================================
	// field views
	logic [4:0] last_slot;
	logic [4:0] first_slot;
	logic [4:0] count_field;
	logic       queue_en;
	logic       trig_en;
	logic [1:0] depth_field;
	logic       fmt_signed;

	assign last_slot   = ctrl_reg[ascd_pkg::LAST_LSB +: ascd_pkg::SLOT_W];
	assign first_slot  = ctrl_reg[ascd_pkg::FIRST_LSB +: ascd_pkg::SLOT_W];
	assign count_field = ctrl_reg[ascd_pkg::COUNT_LSB +: ascd_pkg::COUNT_W];
	assign queue_en    = ctrl_reg[ascd_pkg::QUEUE_BIT];
	assign trig_en     = ctrl_reg[ascd_pkg::TRIG_BIT];
	assign depth_field = ctrl_reg[ascd_pkg::DEPTH_LSB +: 2];
	assign fmt_signed  = ctrl_reg[ascd_pkg::FORMAT_BIT];

	assign o_queue_mode_enable = queue_en;

	// ====================================================
	// bit depth
	ascd_pkg::ascd_depth_e depth;

	always_comb begin
		case (depth_field)
			ascd_pkg::DEPTH_10: depth = ascd_pkg::ASCD_BITS_10;
			ascd_pkg::DEPTH_8:  depth = ascd_pkg::ASCD_BITS_8;
			default:            depth = ascd_pkg::ASCD_BITS_12;
		endcase
	end

	assign o_bit_depth = depth;

	// ====================================================
	// slot sequencer
	typedef enum logic {
		ASCD_IDLE,
		ASCD_RUN
	} ascd_seq_state_e;

	ascd_seq_state_e       state_reg;
	ascd_seq_state_e       state_next;
	ascd_pkg::ascd_seq_mode_e mode;
	logic [4:0]            slot_reg;
	logic [4:0]            slot_next;
	logic                  done_next;
	logic                  done_reg;
	logic                  span_mode;
	logic                  repeat_mode;
	logic                  at_end;

	assign mode        = ascd_pkg::ascd_seq_mode_e'(i_sequence_mode_select);
	assign span_mode   = (mode == ascd_pkg::ASCD_SPAN_ONCE) || (mode == ascd_pkg::ASCD_SPAN_REPEAT);
	assign repeat_mode = (mode == ascd_pkg::ASCD_ONE_SLOT_REPEAT) || (mode == ascd_pkg::ASCD_SPAN_REPEAT);
	// a span also stops at the top slot should first lie beyond last
	assign at_end      = !span_mode || (slot_reg == last_slot) || (slot_reg >= ascd_pkg::SLOT_MAX);

	always_comb begin
		state_next = state_reg;
		slot_next  = slot_reg;
		done_next  = 1'b0;
		case (state_reg)
			ASCD_IDLE: begin
				if (i_seq_start) begin
					state_next = ASCD_RUN;
					slot_next  = first_slot;
				end
			end
			ASCD_RUN: begin
				if (i_sample_valid) begin
					if (!at_end) begin
						slot_next = slot_reg + ascd_pkg::SLOT_ONE;
					end else if (repeat_mode) begin
						slot_next = first_slot;
					end else begin
						state_next = ASCD_IDLE;
						done_next  = 1'b1;
					end
				end
			end
			default: begin
				state_next = ASCD_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= ASCD_IDLE;
			slot_reg  <= 5'h00;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			slot_reg  <= slot_next;
			done_reg  <= done_next;
		end
	end

	assign o_conversion_slot = slot_reg;
	assign o_seq_busy        = (state_reg == ASCD_RUN);
	assign o_seq_done        = done_reg;

	// ====================================================
	// transfer trigger
	logic [4:0] per_trigger;
	logic [4:0] sample_cnt_reg;
	logic [4:0] sample_cnt_next;
	logic       batch_full;
	logic       trigger_next;
	logic       trigger_reg;

	// zero is taken as one sample; values above the maximum are clamped
	assign per_trigger = (count_field == 5'h00)             ? ascd_pkg::COUNT_MIN :
	                     (count_field > ascd_pkg::COUNT_MAX) ? ascd_pkg::COUNT_MAX :
	                                                          count_field;
	assign batch_full   = (sample_cnt_reg + ascd_pkg::COUNT_MIN) >= per_trigger;
	assign trigger_next = trig_en && i_sample_valid && batch_full;

	always_comb begin
		sample_cnt_next = sample_cnt_reg;
		if (!trig_en) begin
			sample_cnt_next = 5'h00;
		end else if (i_sample_valid) begin
			sample_cnt_next = batch_full ? 5'h00 : sample_cnt_reg + ascd_pkg::COUNT_MIN;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sample_cnt_reg <= 5'h00;
			trigger_reg    <= 1'b0;
		end else begin
			sample_cnt_reg <= sample_cnt_next;
			trigger_reg    <= trigger_next;
		end
	end

	assign o_transfer_trigger     = trigger_reg;
	assign o_samples_per_transfer = per_trigger;

	// ====================================================
	// result store and read-back
	logic [11:0] result_reg;
	ascd_fmt_if  fmt_bus ();

	// the raw word is kept unsigned whatever the read format
	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			result_reg <= 12'h000;
		end else if (i_sample_valid) begin
			result_reg <= i_sample_data;
		end
	end

	assign fmt_bus.raw_result = result_reg;
	assign fmt_bus.depth      = depth;
	assign fmt_bus.signed_fmt = fmt_signed;

	ascd_readback_fmt u_fmt (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (rst_n_reg),
		.fmt_io    (fmt_bus)
	);

	assign o_readback_data = fmt_bus.readback;

	// ====================================================
	// read data
	logic [31:0] rdata_next;
	logic [31:0] rdata_reg;

	always_comb begin
		rdata_next = 32'h00000000;
		if (sel_ctrl) begin
			rdata_next = ctrl_reg & ascd_pkg::CTRL_WMASK;
		end else if (sel_result) begin
			rdata_next = {16'h0000, fmt_bus.readback};
		end
	end

	// captured in the setup cycle, presented during the access cycle
	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rdata_reg <= 32'h00000000;
		end else if (setup_phase && !i_pwrite) begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_prdata = rdata_reg;
endmodule

// >>> test/ascd_ctrl_props.sv
// assertion checker for the converter control register block
`timescale 1ns/10ps
module ascd_ctrl_props (
	// clock, reset and apb
	input wire logic        i_ref_clk,
	input wire logic        i_reset_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// converter and transfer side
	input wire logic [1:0]  i_sequence_mode_select,
	input wire logic        i_sample_valid,
	input wire logic [4:0]  o_conversion_slot,
	input wire logic        o_seq_busy,
	input wire logic        o_seq_done,
	input wire logic [1:0]  o_bit_depth,
	input wire logic        o_queue_mode_enable,
	input wire logic        i_transfer_done,
	input wire logic        o_transfer_trigger,
	input wire logic [4:0]  o_samples_per_transfer
);
	// ====================================================
	// shadow of the register and of the synchronised reset
	logic [31:0] shadow_reg;
	logic [1:0]  sync_reg;
	wire         acc = i_psel && i_penable;
	wire         ctl = i_paddr == ascd_pkg::CTRL_OFFSET;
	wire  [4:0]  cnt = shadow_reg[15:11];
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shadow_reg <= 32'h00000000;
			sync_reg   <= 2'h0;
		end else begin
			sync_reg <= {sync_reg[0], 1'b1};
			// the block's own register stays in reset until the second edge
			if (sync_reg[1] && acc && i_pwrite && ctl)
				shadow_reg <= i_pwdata & ascd_pkg::CTRL_WMASK;
			else if (sync_reg[1] && i_transfer_done)
				shadow_reg[8] <= 1'b0;
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!sync_reg[1]);
	// ====================================================
	// properties
	property p_apb;
		acc |-> o_pready && o_pslverr == !(ctl || i_paddr == ascd_pkg::RESULT_OFFSET);
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer wrong");
	property p_read;
		acc && !i_pwrite && ctl |-> o_prdata == $past(shadow_reg);
	endproperty
	a_read: assert property (p_read) else $error("control read data wrong");
	property p_count;
		o_samples_per_transfer == (cnt == 5'h00 ? 5'h01 : (cnt > 5'h18 ? 5'h18 : cnt));
	endproperty
	a_count: assert property (p_count) else $error("sample count wrong");
	property p_depth;
		o_bit_depth == (shadow_reg[2:1] == 2'h3 ? 2'h0 : shadow_reg[2:1]);
	endproperty
	a_depth: assert property (p_depth) else $error("bit depth wrong");
	property p_queue;
		o_queue_mode_enable == shadow_reg[10];
	endproperty
	a_queue: assert property (p_queue) else $error("queue mode wrong");
	property p_trig;
		o_transfer_trigger |-> $past(shadow_reg[8]) && $past(i_sample_valid);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger while disabled");
	property p_first;
		$rose(o_seq_busy) |-> o_conversion_slot == shadow_reg[20:16];
	endproperty
	a_first: assert property (p_first) else $error("first slot wrong");
	// a span ends at the last slot, or at the top slot when first lies beyond last
	property p_done;
		o_seq_done |-> $past(i_sample_valid) && !$past(i_sequence_mode_select[1]) &&
			(!$past(i_sequence_mode_select[0]) || $past(o_conversion_slot) == shadow_reg[28:24] ||
			$past(o_conversion_slot) >= 5'h17);
	endproperty
	a_done: assert property (p_done) else $error("sequence end wrong");
	c_trig: cover property (o_transfer_trigger);
	c_done: cover property (o_seq_done);
	c_err: cover property (acc && o_pslverr);
endmodule

// >>> test/ascd_dma_model.sv
// transfer controller model: answers the last trigger with a done pulse
`timescale 1ns/10ps
module ascd_dma_model (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	// block side
	input  wire logic       i_trigger,
	input  wire logic [3:0] i_lag,
	output logic            o_done,
	output logic [7:0]      o_trig_count
);
	logic [3:0] wait_reg;
	logic       busy_reg;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_done       <= 1'b0;
			o_trig_count <= 8'h00;
			wait_reg     <= 4'h0;
			busy_reg     <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_trigger) begin
				o_trig_count <= o_trig_count + 8'h01;
				busy_reg     <= 1'b1;
				wait_reg     <= i_lag;
			end else if (busy_reg && wait_reg == 4'h0) begin
				busy_reg <= 1'b0;
				o_done   <= 1'b1;
			end else if (busy_reg) begin
				wait_reg <= wait_reg - 4'h1;
			end
		end
	end
endmodule

// >>> test/testbench.sv
// self-checking bench for the converter control register block
`timescale 1ns/10ps
module testbench;
	// ====================================================
	// signals
	localparam logic [15:0] CTL = ascd_pkg::CTRL_OFFSET;
	localparam logic [15:0] RDB = ascd_pkg::RESULT_OFFSET;
	logic        i_ref_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [15:0] i_paddr = 16'h0000;
	logic [31:0] i_pwdata = 32'h00000000;
	logic [1:0]  i_sequence_mode_select = 2'h0;
	logic        i_seq_start = 1'b0;
	logic        i_sample_valid = 1'b0;
	logic [11:0] i_sample_data = 12'h000;
	logic [3:0]  lag = 4'h0;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic [4:0]  o_conversion_slot;
	logic        o_seq_busy;
	logic        o_seq_done;
	logic [1:0]  o_bit_depth;
	logic        o_queue_mode_enable;
	logic        i_transfer_done;
	logic        o_transfer_trigger;
	logic [4:0]  o_samples_per_transfer;
	logic [15:0] o_readback_data;
	logic [7:0]  trig_count;
	logic [31:0] q;
	logic        e;
	int          bad_count = 0;
	int          n_tests = 0;
	ascd_ctrl_top dut (.i_ref_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
		.o_pready, .o_pslverr, .i_sequence_mode_select, .i_seq_start, .i_sample_valid, .i_sample_data,
		.o_conversion_slot, .o_seq_busy, .o_seq_done, .o_bit_depth, .o_queue_mode_enable, .i_transfer_done,
		.o_transfer_trigger, .o_samples_per_transfer, .o_readback_data);
	ascd_dma_model dma (.i_ref_clk, .i_reset_n, .i_trigger(o_transfer_trigger), .i_lag(lag),
		.o_done(i_transfer_done), .o_trig_count(trig_count));
	initial forever #12.5 i_ref_clk = ~i_ref_clk;
	// ====================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		do
			@(posedge i_ref_clk);
		while (o_pready !== 1'b1);
		q = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		// let the write edge settle before the caller looks at outputs
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h00000000);
		chk(q, x);
	endtask
	// one start pulse or one sample pulse; returns just after its sampling edge
	task automatic pls(input logic st, input logic [11:0] d);
		@(posedge i_ref_clk);
		i_sample_data <= d;
		i_seq_start <= st;
		i_sample_valid <= !st;
		@(posedge i_ref_clk);
		i_seq_start <= 1'b0;
		i_sample_valid <= 1'b0;
		#1;
	endtask
	task automatic do_reset();
		@(posedge i_ref_clk);
		i_reset_n <= 1'b0;
		repeat (12) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
	endtask
	// signed read: raw minus midscale, shifted up to the top of 16 bits
	function automatic logic [15:0] fmt(input logic [1:0] dep, input logic sg, input logic [11:0] r);
		int n;
		n = (dep == 2'h1) ? 10 : ((dep == 2'h2) ? 8 : 12);
		if (!sg)
			return {4'h0, r};
		return 16'((int'(r) - (1 << (n - 1))) << (16 - n));
	endfunction
	task automatic give_verdict();
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ====================================================
	// tests
	initial begin
		logic [11:0] r;
		do_reset();
		rd(CTL, ascd_pkg::CTRL_RESET);
		apb(1'b1, 16'h1104, 32'hFFFFFFFF);
		chk(e, 1'b1);
		rd(16'h1104, 32'h00000000);
		chk(e, 1'b1);
		apb(1'b1, CTL, 32'hFFFFFFFF);
		rd(CTL, ascd_pkg::CTRL_WMASK);
		chk(o_queue_mode_enable, 1'b1);
		chk(o_samples_per_transfer, 5'h18);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, CTL, {29'h0, k[2:0]});
			r = 12'hA5C >> ((k[2:1] == 2'h3) ? 0 : 2 * k[2:1]);
			pls(1'b0, r);
			chk(o_bit_depth, (k[2:1] == 2'h3) ? 2'h0 : k[2:1]);
			rd(RDB, {16'h0, fmt(k[2:1], k[0], r)});
			chk(o_readback_data, fmt(k[2:1], k[0], r));
		end
		chk(o_queue_mode_enable, 1'b0);
		for (int m = 0; m < 4; m++) begin
			do_reset();
			i_sequence_mode_select <= m[1:0];
			apb(1'b1, CTL, 32'h04020000);
			pls(1'b1, 12'h000);
			chk(o_conversion_slot, 5'h02);
			chk(o_seq_busy, 1'b1);
			pls(1'b0, 12'h001);
			if (m[0]) begin
				chk(o_conversion_slot, 5'h03);
				pls(1'b0, 12'h002);
				chk(o_conversion_slot, 5'h04);
				pls(1'b0, 12'h003);
			end
			chk(o_seq_done, !m[1]);
			chk(o_seq_busy, m[1]);
			if (m[1])
				chk(o_conversion_slot, 5'h02);
		end
		lag <= 4'h6;
		apb(1'b1, CTL, 32'h00001100);
		pls(1'b0, 12'h011);
		pls(1'b0, 12'h012);
		repeat (12) @(posedge i_ref_clk);
		chk(trig_count, 8'h01);
		rd(CTL, 32'h00001000);
		pls(1'b0, 12'h013);
		pls(1'b0, 12'h014);
		repeat (3) @(posedge i_ref_clk);
		chk(trig_count, 8'h01);
		lag <= 4'h0;
		apb(1'b1, CTL, 32'h00000100);
		chk(o_samples_per_transfer, 5'h01);
		pls(1'b0, 12'h015);
		repeat (4) @(posedge i_ref_clk);
		chk(trig_count, 8'h02);
		rd(CTL, 32'h00000000);
		give_verdict();
	end
	initial begin
		repeat (4000) @(posedge i_ref_clk);
		bad_count++;
		give_verdict();
	end
endmodule
bind ascd_ctrl_top ascd_ctrl_props props (.i_ref_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sequence_mode_select, .i_sample_valid, .o_conversion_slot,
	.o_seq_busy, .o_seq_done, .o_bit_depth, .o_queue_mode_enable, .i_transfer_done, .o_transfer_trigger,
	.o_samples_per_transfer);
